// ### core/lfs_top.sv
// Purpose: Serial configuration port and command decoder of an LF front end.
// Assumes: mclk at 100 MHz, serial clock much slower; pins split in three.
// Notes: Commands act when chip select rises after whole frames.
// Summary of operation
// - Clock pin is open-collector alert while select high, serial clock when low.
// - Data pin drives received data when idle unless strength output selected, input in frames, output in results.
// - Frame is command 3 bits, address 4, data byte 8, parity 1, MSB first.
// - Mode 0,0: clock idles low, sample on rise, change output on fall.
// - Clocks per select-low interval must be a multiple of 16, else abort.
// - Result frame is seven dummy bits, eight data bits, then row parity.
// - Select-high gap counts as no clock; data appears from eighth clock after.
// - Codes 000 to 101 are command-only; address, data, parity ignored.
// - Code 000 turns on modulation only of channels whose enable bit in address 0 is clear.
// - Code 001 turns off modulation of all channels.
// - Code 010 sleeps; any other valid command wakes.
// - 011 freezes gain, 100 releases it, 101 soft resets internal blocks.
// - Code 110 reads addressed register; 0-5 config, 6 column parity, 7 status.
// - Code 111 writes byte and parity; writing address 7 has no effect.
// - Config parity bit gives odd parity; status parity position is not parity.
// - Address 6 holds column parity over config bytes zero to five.
// - Pull-down follows its enable bit only while signal-strength output selected.
// - Soft reset is ignored when the front end is not active.
// - Soft reset leaves an active modulation clamp on.
// - A transfer suspends signal-strength output until it finishes.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_top (
    // System.
    input wire logic mclk,
    input wire logic rst_b,
    // Chip select pin.
    input wire logic cs_pin_b,
    // Shared clock and alert pin.
    input wire logic sclk_alert_in,
    output logic sclk_alert_out,
    output logic sclk_alert_oe,
    // Shared data pin.
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // Analog side inputs.
    input wire logic demod_in,
    input wire logic carrier_in,
    input wire logic alarm_in,
    input wire logic active_in,
    input wire logic [8:0] status_in,
    // Analog side controls.
    output logic [2:0] mod_clamp_out,
    output logic sleep_out,
    output logic gain_hold_out,
    output logic soft_reset_out,
    output logic signal_strength_out,
    output logic strength_pulldown_enable,
    output logic [62:0] config_out
);
    lfs_link_if link ();

    lfs_pkg::lfs_row_t cfg_reg [0:6];
    logic [1:0] an_sync1_reg [0:3];
    logic [3:0] an_sync2_reg;
    logic [8:0] st_sync1_reg;
    logic [8:0] st_sync2_reg;
    logic [15:0] pend_reg;
    logic pend_valid_reg;
    logic read_pend_reg;
    logic [3:0] read_addr_reg;
    logic [2:0] mod_reg;
    logic sleep_reg;
    logic hold_reg;
    logic srst_reg;
    logic par_err_reg;
    logic alert_oe_reg;
    logic alert_out_reg;
    logic data_out_reg;
    logic data_oe_reg;
    logic signal_strength_out_reg;
    logic pull_reg;
    logic exec;
    lfs_pkg::lfs_cmd_t cmd;
    logic [3:0] addr;
    logic [8:0] wdata;
    logic [2:0] chan_on;
    logic signal_strength_out_mode;

    // Odd parity check of one row.
    function automatic logic row_odd(input logic [8:0] v);
        row_odd = ^v;
    endfunction

    // Register read decode used only by the result frame; parity logic reads cfg_reg directly.
    function automatic logic [8:0] reg_read(input logic [3:0] a,
        input logic [8:0] st);
        logic [8:0] r;
        r = 9'h000;
        if (a == `LFS_ADDR_STATUS) begin
            r = st;
        end else if (a < `LFS_ADDR_STATUS) begin
            r = cfg_reg[a[2:0]];
        end
        reg_read = r;
    endfunction

    lfs_shifter u_shifter (
        .mclk(mclk),
        .rst_b(rst_b),
        .cs_pin_b(cs_pin_b),
        .sclk_pin(sclk_alert_in),
        .sdi_pin(sdio_in),
        .link(link)
    );

    // Analog levels cross in through three flops each, status through two.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                an_sync1_reg[i] <= 2'h0;
            end
            an_sync2_reg <= 4'h0;
            st_sync1_reg <= 9'h000;
            st_sync2_reg <= 9'h000;
        end else begin
            an_sync1_reg[0] <= {an_sync1_reg[0][0], demod_in};
            an_sync1_reg[1] <= {an_sync1_reg[1][0], carrier_in};
            an_sync1_reg[2] <= {an_sync1_reg[2][0], alarm_in};
            an_sync1_reg[3] <= {an_sync1_reg[3][0], active_in};
            for (int i = 0; i < 4; i++) begin
                an_sync2_reg[i] <= an_sync1_reg[i][1];
            end
            st_sync1_reg <= status_in;
            st_sync2_reg <= st_sync1_reg;
        end
    end

    // Decoded fields of the frame waiting for chip select to rise.
    assign cmd = lfs_pkg::lfs_cmd_t'(pend_reg[`LFS_CMD_MSB:`LFS_CMD_LSB]);
    assign addr = pend_reg[`LFS_ADDR_MSB:`LFS_ADDR_LSB];
    assign wdata = pend_reg[`LFS_DATA_MSB:`LFS_DATA_LSB];
    assign exec = link.cs_rise & link.aligned & pend_valid_reg;
    assign chan_on = ~cfg_reg[0][`LFS_CHAN_EN_MSB:`LFS_CHAN_EN_LSB];
    assign signal_strength_out_mode = cfg_reg[1][`LFS_OUTSEL_MSB];
    assign link.tx_word = {`LFS_READ_PAD, reg_read(read_addr_reg, st_sync2_reg)};

    // Deferring action to the rise of select lets a short interval abort cleanly.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= 16'h0000;
            pend_valid_reg <= 1'b0;
        end else if (link.cs_rise) begin
            pend_valid_reg <= 1'b0;
        end else if (link.frame_done & ~read_pend_reg) begin
            pend_reg <= link.frame_word;
            pend_valid_reg <= 1'b1;
        end
    end

    // Read is split over two intervals; the result survives an aborted one.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            read_pend_reg <= 1'b0;
            read_addr_reg <= 4'h0;
        end else if (exec && cmd == lfs_pkg::LFS_READ) begin
            read_pend_reg <= 1'b1;
            read_addr_reg <= addr;
        end else if (link.cs_rise & link.aligned & read_pend_reg) begin
            read_pend_reg <= 1'b0;
        end
    end

    // Register writes; status is read-only and never stored.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 7; i++) begin
                cfg_reg[i] <= `LFS_CFG_RESET;
            end
        end else if (exec && cmd == lfs_pkg::LFS_WRITE && addr < `LFS_ADDR_STATUS) begin
            cfg_reg[addr[2:0]] <= wdata;
        end
    end

    // Modulation clamp; soft reset deliberately leaves it alone.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mod_reg <= 3'h0;
        end else if (exec && cmd == lfs_pkg::LFS_CLAMP_ON) begin
            mod_reg <= mod_reg | chan_on;
        end else if (exec && cmd == lfs_pkg::LFS_CLAMP_OFF) begin
            mod_reg <= 3'h0;
        end
    end

    // Sleep, gain hold and soft reset; address and data are ignored here.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_reg <= 1'b0;
            hold_reg <= 1'b0;
            srst_reg <= 1'b0;
        end else begin
            srst_reg <= 1'b0;
            if (exec) begin
                sleep_reg <= (cmd == lfs_pkg::LFS_SLEEP);
                if (cmd == lfs_pkg::LFS_HOLD_ON) begin
                    hold_reg <= 1'b1;
                end
                if (cmd == lfs_pkg::LFS_HOLD_OFF) begin
                    hold_reg <= 1'b0;
                end
                if (cmd == lfs_pkg::LFS_SOFT_RST) begin
                    srst_reg <= an_sync2_reg[3] & ~sleep_reg;
                end
            end
        end
    end

    // Row and column parity; a cleared map fails and so raises the alert.
    always_ff @(posedge mclk or negedge rst_b) begin
        logic bad;
        logic [8:1] col;
        bad = 1'b0;
        col = 8'h00;
        if (!rst_b) begin
            par_err_reg <= 1'b1;
        end else begin
            for (int i = 0; i < 7; i++) begin
                bad = bad | ~row_odd(cfg_reg[i]);
                col = col ^ cfg_reg[i][8:1];
            end
            par_err_reg <= bad | (col != 8'hFF);
        end
    end

    // Alert pulls the clock pin low only while select is high.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_oe_reg <= 1'b0;
            alert_out_reg <= 1'b0;
        end else begin
            alert_out_reg <= 1'b0;
            alert_oe_reg <= ~link.cs_low & (par_err_reg |
                (an_sync2_reg[2] & cfg_reg[0][`LFS_ALRTIND_BIT]));
        end
    end

    // Data pin source; signal strength is analog so the digital driver lets go.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_reg <= 1'b0;
            data_oe_reg <= 1'b0;
        end else if (link.cs_low) begin
            data_out_reg <= link.sdo;
            data_oe_reg <= read_pend_reg;
        end else begin
            data_out_reg <= cfg_reg[1][`LFS_OUTSEL_LSB] ? an_sync2_reg[1] : an_sync2_reg[0];
            data_oe_reg <= ~signal_strength_out_mode;
        end
    end

    // Strength output pauses during a transfer; pull-down obeys only in that mode.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            signal_strength_out_reg <= 1'b0;
            pull_reg <= 1'b0;
        end else begin
            signal_strength_out_reg <= signal_strength_out_mode & ~link.cs_low;
            pull_reg <= signal_strength_out_mode & cfg_reg[2][`LFS_PULLDOWN_BIT];
        end
    end

    assign sclk_alert_out = alert_out_reg;
    assign sclk_alert_oe = alert_oe_reg;
    assign sdio_out = data_out_reg;
    assign sdio_oe = data_oe_reg;
    assign mod_clamp_out = mod_reg;
    assign sleep_out = sleep_reg;
    assign gain_hold_out = hold_reg;
    assign soft_reset_out = srst_reg;
    assign signal_strength_out = signal_strength_out_reg;
    assign strength_pulldown_enable = pull_reg;
    assign config_out = {cfg_reg[6], cfg_reg[5], cfg_reg[4], cfg_reg[3],
        cfg_reg[2], cfg_reg[1], cfg_reg[0]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    clamp_off_clear_a: assert property (exec && cmd == lfs_pkg::LFS_CLAMP_OFF
        |=> mod_clamp_out == 3'h0) else $error("clamp off left a channel on");
    clamp_on_mask_a: assert property (exec && cmd == lfs_pkg::LFS_CLAMP_ON
        |=> mod_clamp_out == ($past(mod_reg) | $past(chan_on)))
        else $error("clamp on touched wrong channels");
    sleep_enter_a: assert property (exec && cmd == lfs_pkg::LFS_SLEEP
        |=> sleep_out) else $error("sleep not entered");
    sleep_wake_a: assert property (sleep_out && exec && cmd != lfs_pkg::LFS_SLEEP
        |=> !sleep_out) else $error("front end did not wake");
    gain_hold_a: assert property (exec && cmd == lfs_pkg::LFS_HOLD_ON
        |=> gain_hold_out ##0 $stable(mod_clamp_out)) else $error("gain not held");
    write_store_a: assert property (exec && cmd == lfs_pkg::LFS_WRITE
        && addr < `LFS_ADDR_STATUS |=> cfg_reg[$past(addr[2:0])] == $past(wdata))
        else $error("write not stored");
    abort_stable_a: assert property (link.cs_rise && !link.aligned
        |=> $stable(mod_clamp_out) && $stable(sleep_out) && $stable(config_out)
        && !soft_reset_out) else $error("aborted frame changed state");
    soft_idle_a: assert property (exec && cmd == lfs_pkg::LFS_SOFT_RST
        && !an_sync2_reg[3] |=> !soft_reset_out) else $error("soft reset while idle");
    clamp_keep_a: assert property (exec && cmd == lfs_pkg::LFS_SOFT_RST
        |=> $stable(mod_clamp_out)) else $error("soft reset dropped clamp");
    alert_select_a: assert property (link.cs_low [*2]
        |-> !sclk_alert_oe) else $error("alert driven during transfer");
    data_input_a: assert property (link.cs_low && !read_pend_reg
        |=> !sdio_oe) else $error("data pin driven in input frame");
    strength_pause_a: assert property (link.cs_low |=> !signal_strength_out
        ##0 (strength_pulldown_enable == (signal_strength_out_mode && cfg_reg[2][8])))
        else $error("strength output not paused");

    write_seen_c: cover property (exec && cmd == lfs_pkg::LFS_WRITE);
    read_done_c: cover property (link.cs_rise && link.aligned && read_pend_reg);
    abort_seen_c: cover property (link.cs_rise && !link.aligned && pend_valid_reg);
    sleep_wake_c: cover property (sleep_out ##[1:1000] !sleep_out);
endmodule
`default_nettype wire

// ### core/lfs_consts.svh
// Purpose: Frame layout, command codes, register map and field positions.
// Assumes: Included by bare name from every core file except the link interface.
// Notes: Definitions only.
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_FRAME_BITS 16
`define LFS_CMD_MSB 15
`define LFS_CMD_LSB 13
`define LFS_ADDR_MSB 12
`define LFS_ADDR_LSB 9
`define LFS_DATA_MSB 8
`define LFS_DATA_LSB 0
`define LFS_CMD_CLAMP_ON 3'h0
`define LFS_CMD_CLAMP_OFF 3'h1
`define LFS_CMD_SLEEP 3'h2
`define LFS_CMD_HOLD_ON 3'h3
`define LFS_CMD_HOLD_OFF 3'h4
`define LFS_CMD_SOFT_RST 3'h5
`define LFS_CMD_READ 3'h6
`define LFS_CMD_WRITE 3'h7
`define LFS_ADDR_GENERAL 4'h0
`define LFS_ADDR_XTUNE 4'h1
`define LFS_ADDR_YTUNE 4'h2
`define LFS_ADDR_COLPAR 4'h6
`define LFS_ADDR_STATUS 4'h7
`define LFS_CFG_RESET 9'h000
`define LFS_READ_PAD 7'h00
`define LFS_OUTSEL_MSB 8
`define LFS_OUTSEL_LSB 7
`define LFS_PULLDOWN_BIT 8
`define LFS_ALRTIND_BIT 4
`define LFS_CHAN_EN_MSB 3
`define LFS_CHAN_EN_LSB 1
`endif

// ### core/lfs_pkg.sv
// Purpose: Shared types of the front end serial port.
// Assumes: Constants come from lfs_consts.svh.
// Notes: Nothing here is imported; users write lfs_pkg::name.
`include "lfs_consts.svh"
package lfs_pkg;
    typedef logic [8:0] lfs_row_t;
    typedef enum logic [2:0] {
        LFS_CLAMP_ON = `LFS_CMD_CLAMP_ON,
        LFS_CLAMP_OFF = `LFS_CMD_CLAMP_OFF,
        LFS_SLEEP = `LFS_CMD_SLEEP,
        LFS_HOLD_ON = `LFS_CMD_HOLD_ON,
        LFS_HOLD_OFF = `LFS_CMD_HOLD_OFF,
        LFS_SOFT_RST = `LFS_CMD_SOFT_RST,
        LFS_READ = `LFS_CMD_READ,
        LFS_WRITE = `LFS_CMD_WRITE
    } lfs_cmd_t;
endpackage

// ### core/lfs_link_if.sv
// Purpose: Carries frames between the pin shifter and the decoder.
// Assumes: Both ends run on mclk.
// Notes: Pulses last one mclk cycle.
`timescale 1ns/1ps
`default_nettype none
interface lfs_link_if;
    logic cs_low;
    logic cs_rise;
    logic aligned;
    logic frame_done;
    logic [15:0] frame_word;
    logic [15:0] tx_word;
    logic sdo;
    modport shf (output cs_low, cs_rise, aligned, frame_done, frame_word, sdo,
        input tx_word);
    modport ctl (input cs_low, cs_rise, aligned, frame_done, frame_word, sdo,
        output tx_word);
endinterface
`default_nettype wire

// ### core/lfs_shifter.sv
// Purpose: Samples the serial pins and shifts 16-bit frames in and out.
// Assumes: Serial clock is far slower than mclk.
// Notes: Edges are found on synchronised copies of the pins.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_shifter (
    // System.
    input wire logic mclk,
    input wire logic rst_b,
    // Pin inputs.
    input wire logic cs_pin_b,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    // Decoder side.
    lfs_link_if.shf link
);
    logic [1:0] cs_sync_reg;
    logic [1:0] ck_sync_reg;
    logic [1:0] di_sync_reg;
    logic cs_last_reg;
    logic ck_last_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [15:0] word_reg;
    logic [3:0] cnt_reg;
    logic any_reg;
    logic done_reg;
    logic rise_reg;
    logic aligned_reg;
    logic sel;
    logic ck_rise;
    logic ck_fall;

    // Two flops on every pin before any logic looks at it.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_reg <= 2'h3;
            ck_sync_reg <= 2'h0;
            di_sync_reg <= 2'h0;
            cs_last_reg <= 1'b1;
            ck_last_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], cs_pin_b};
            ck_sync_reg <= {ck_sync_reg[0], sclk_pin};
            di_sync_reg <= {di_sync_reg[0], sdi_pin};
            cs_last_reg <= cs_sync_reg[1];
            ck_last_reg <= ck_sync_reg[1];
        end
    end

    assign sel = ~cs_sync_reg[1];
    assign ck_rise = sel & ck_sync_reg[1] & ~ck_last_reg;
    assign ck_fall = sel & ~ck_sync_reg[1] & ck_last_reg;

    // Input on rising edges, output on falling edges, MSB first.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            word_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            any_reg <= 1'b0;
            done_reg <= 1'b0;
            rise_reg <= 1'b0;
            aligned_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            rise_reg <= ~cs_last_reg & cs_sync_reg[1];
            aligned_reg <= (cnt_reg == 4'h0) & any_reg;
            if (cs_last_reg & ~cs_sync_reg[1]) begin
                cnt_reg <= 4'h0;
                any_reg <= 1'b0;
                tx_reg <= link.tx_word;
            end else begin
                if (ck_rise) begin
                    rx_reg <= {rx_reg[14:0], di_sync_reg[1]};
                    cnt_reg <= cnt_reg + 4'h1;
                    any_reg <= 1'b1;
                    done_reg <= (cnt_reg == 4'hF);
                    if (cnt_reg == 4'hF) begin
                        word_reg <= {rx_reg[14:0], di_sync_reg[1]};
                    end
                end
                if (ck_fall) begin
                    tx_reg <= {tx_reg[14:0], 1'b0};
                end
            end
        end
    end

    assign link.cs_low = sel;
    assign link.cs_rise = rise_reg;
    assign link.aligned = aligned_reg;
    assign link.frame_done = done_reg;
    assign link.frame_word = word_reg;
    assign link.sdo = tx_reg[15];
endmodule
`default_nettype wire

// ### verif/lfs_host_model.sv
// Purpose: Host controller model that drives the serial port in clock mode 0,0.
// Assumes: Link clock period 125 ns, unrelated to mclk.
// Notes: Released data line shows the inverse of the last bit driven.
`timescale 1ns/1ps
`default_nettype none
module lfs_host_model (
    // Pins driven by the host.
    output logic cs_b,
    output logic sclk,
    output logic sclk_oe,
    output logic dat,
    output logic dat_oe,
    // Data wire as the host sees it.
    input wire logic dat_line
);
    // Pins start released until the host sets them up.
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        sclk_oe = 1'b0;
        dat = 1'b0;
        dat_oe = 1'b0;
    end

    // One select-low interval of n clocks; the word repeats every 16 clocks.
    task automatic xfer(input logic [15:0] w, input int n, input bit rd, output logic [15:0] got);
        got = 16'h0000;
        // A short pause keeps a back-to-back call from re-taking the clock pin in the same step.
        #10 sclk_oe = 1'b1;
        #62.5 cs_b = 1'b0;
        dat_oe = !rd;
        #100;
        for (int i = 0; i < n; i++) begin
            dat = w[15 - (i % 16)];
            #62.5 sclk = 1'b1;
            got = {got[14:0], dat_line};
            #62.5 sclk = 1'b0;
        end
        #50 dat_oe = 1'b0;
        dat = ~dat;
        #50 cs_b = 1'b1;
        #62.5 sclk_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verif/lfs_top_tb_top.sv
// Purpose: Self-checking bench for the front end serial port.
// Assumes: Host model drives the link; bench drives the analog side at mclk fall.
// Notes: Command results are looked at 62.5 ns plus 10 mclk after select rises.
`timescale 1ns/1ps
`default_nettype none
module lfs_top_tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, h_sclk, h_sclk_oe, h_dat, h_dat_oe, sck_w, sd_w;
    logic demod_in = 1'b0;
    logic active_in = 1'b1;
    logic [8:0] status_in = 9'h1A5;
    logic al_out, al_oe, sd_out, sd_oe, gain, slp, srst, sso, pde;
    logic [2:0] clamp;
    logic [62:0] cfg;
    logic [15:0] got;
    logic [7:0] b [0:6];
    int err_count = 0;
    int checks = 0;
    int srst_cnt = 0;

    always #5 mclk = ~mclk;

    // Clock wire has a pull-up; either party may pull it low.
    assign sck_w = (h_sclk_oe ? h_sclk : 1'b1) & !(al_oe & !al_out);
    assign sd_w = sd_oe ? sd_out : h_dat;

    lfs_host_model i_host (.cs_b(cs_b), .sclk(h_sclk), .sclk_oe(h_sclk_oe), .dat(h_dat),
        .dat_oe(h_dat_oe), .dat_line(sd_w));

    lfs_top i_dut (.mclk(mclk), .rst_b(rst_b), .cs_pin_b(cs_b), .sclk_alert_in(sck_w),
        .sclk_alert_out(al_out), .sclk_alert_oe(al_oe), .sdio_in(sd_w), .sdio_out(sd_out),
        .sdio_oe(sd_oe), .demod_in(demod_in), .carrier_in(1'b0), .alarm_in(1'b0),
        .active_in(active_in), .status_in(status_in), .mod_clamp_out(clamp),
        .sleep_out(slp), .gain_hold_out(gain), .soft_reset_out(srst),
        .signal_strength_out(sso), .strength_pulldown_enable(pde), .config_out(cfg));

    // The soft reset pulse lasts one cycle, so it is counted rather than sampled.
    always @(posedge mclk) if (srst === 1'b1) srst_cnt++;

    task automatic results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_host.xfer({3'h7, a, d, ~^d}, 16, 1'b0, got);
        repeat (10) @(negedge mclk);
    endtask

    task automatic rd(input logic [3:0] a);
        i_host.xfer({3'h6, a, 9'h000}, 16, 1'b0, got);
        i_host.xfer(16'hFFFF, 16, 1'b1, got);
    endtask

    // Address and data carry junk, which a command-only frame must ignore.
    task automatic cmd(input logic [2:0] c);
        i_host.xfer({c, 13'h1FFF}, 16, 1'b0, got);
        repeat (10) @(negedge mclk);
    endtask

    task automatic t_reset;
        chk("cfg", 16'h0000, cfg[15:0]);
        chk("alert", 16'h0001, al_oe);
        chk("alert out", 16'h0000, al_out);
        chk("clamp", 16'h0000, clamp);
    endtask

    task automatic t_regs;
        b = '{8'h05, 8'h3C, 8'h5A, 8'h1F, 8'hC3, 8'h66, 8'h00};
        for (int a = 0; a < 6; a++) wr(a[3:0], b[a]);
        b[6] = ~(b[0] ^ b[1] ^ b[2] ^ b[3] ^ b[4] ^ b[5]);
        wr(4'h6, b[6]);
        chk("alert", 16'h0000, al_oe);
        for (int a = 0; a < 7; a++) begin
            rd(a[3:0]);
            chk("rdata", {7'h00, b[a], ~^b[a]}, got);
            chk("cfg", {7'h00, b[a], ~^b[a]}, cfg[a*9 +: 9]);
        end
        wr(4'h7, 8'hFF);
        rd(4'h7);
        chk("status", {7'h00, status_in}, got);
    endtask

    task automatic t_cmds;
        cmd(3'h0);
        chk("clamp", 16'h0002, clamp);
        cmd(3'h2);
        chk("sleep", 16'h0001, slp);
        cmd(3'h3);
        chk("sleep", 16'h0000, slp);
        chk("gain", 16'h0001, gain);
        cmd(3'h5);
        chk("srst", 16'h0001, srst_cnt[15:0]);
        chk("clamp", 16'h0002, clamp);
        active_in = 1'b0;
        cmd(3'h5);
        chk("srst", 16'h0001, srst_cnt[15:0]);
        active_in = 1'b1;
        cmd(3'h4);
        chk("gain", 16'h0000, gain);
        cmd(3'h1);
        chk("clamp", 16'h0000, clamp);
    endtask

    task automatic t_pins;
        demod_in = 1'b1;
        repeat (6) @(negedge mclk);
        chk("sdio", 16'h0003, {sd_oe, sd_out});
        demod_in = 1'b0;
        repeat (6) @(negedge mclk);
        chk("sdio", 16'h0002, {sd_oe, sd_out});
        wr(4'h1, 8'h80);
        wr(4'h2, 8'h80);
        chk("strength", 16'h0006, {sso, pde, sd_oe});
        fork
            cmd(3'h4);
            begin
                #600;
                chk("in frame", 16'h0000, {sso, al_oe, sd_oe});
            end
        join
        chk("strength", 16'h0001, sso);
        wr(4'h1, 8'h00);
        chk("pulldown", 16'h0000, {sso, pde});
    endtask

    task automatic t_abort;
        i_host.xfer({3'h7, 4'h3, 8'hAA, 1'b1}, 15, 1'b0, got);
        repeat (10) @(negedge mclk);
        chk("abort", {7'h00, b[3], ~^b[3]}, cfg[35:27]);
        i_host.xfer({3'h7, 4'h3, 8'hAA, 1'b1}, 32, 1'b0, got);
        repeat (10) @(negedge mclk);
        chk("two frames", 16'h0155, cfg[35:27]);
    endtask

    initial begin
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        repeat (6) @(negedge mclk);
        t_reset();
        t_regs();
        t_cmds();
        t_pins();
        t_abort();
        results();
    end

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
